// ### include/ccc_defines.svh
// Constants for the charge cycle controller: offsets, fields, resets, timing.
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices on the host write port
// ----------------------------------------------------------------------
`define CCC_IDX_CFG1 3'h1
`define CCC_IDX_FLOAT 3'h2
`define CCC_IDX_CUR 3'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCC_WEAK_MSB 5
`define CCC_WEAK_LSB 4
`define CCC_TE_BIT 3
`define CCC_DIS_BIT 2
`define CCC_HZ_BIT 1
`define CCC_FLOAT_MSB 7
`define CCC_FLOAT_LSB 2
`define CCC_RST_BIT 7
`define CCC_CHG_MSB 6
`define CCC_CHG_LSB 4
`define CCC_TERM_MSB 2
`define CCC_TERM_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCC_DEF_FLOAT 6'h02
`define CCC_DEF_CHG 3'h0
`define CCC_DEF_TERM 3'h0
`define CCC_DEF_WEAK 2'h0
`define CCC_DEF_TE 1'h0

// ----------------------------------------------------------------------
// Float voltage mapping in millivolts
// ----------------------------------------------------------------------
`define CCC_FLOAT_BASE_MV 13'h0DAC
`define CCC_FLOAT_STEP_MV 13'h0014
`define CCC_FLOAT_MAX_CODE 6'h2F

// ----------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------
`define CCC_STAT_READY 2'h0
`define CCC_STAT_CHARGING 2'h1
`define CCC_STAT_DONE 2'h2

// ----------------------------------------------------------------------
// Timing: times in their own unit, cycles derived from the clock rate
// ----------------------------------------------------------------------
`define CCC_CLK_KHZ 125000
`define CCC_READY_HOLD_MS 500
`define CCC_READY_HOLD_CYC (`CCC_READY_HOLD_MS * `CCC_CLK_KHZ)
`define CCC_DERATE_STEP_US 10
`define CCC_DERATE_STEP_CYC (`CCC_DERATE_STEP_US * `CCC_CLK_KHZ / 1000)

`endif

// ### include/ccc_pkg.sv
// Types shared by the charge cycle controller files.
package ccc_pkg;

   // Analog comparator and presence levels seen by the controller.
   typedef struct packed {
      logic below_short;
      logic below_weak;
      logic below_rech;
      logic at_float;
      logic iout_below_term;
      logic tj_hot;
      logic vin_below_hold;
      logic vin_ok;
      logic batt_present;
      logic src_present;
   } ccc_sense_t;

   // Host-programmed charging parameters as held.
   typedef struct packed {
      logic [5:0] float_voltage_code;
      logic [2:0] charge_current_code;
      logic [2:0] termination_current_code;
      logic [1:0] weak_battery_threshold;
      logic termination_enable;
      logic charge_disable;
      logic high_impedance_select;
   } ccc_params_t;

   // Charge sequencer states, one-hot.
   typedef enum logic [5:0] {
      ST_HIZ = 6'h01,
      ST_IDLE = 6'h02,
      ST_PRE = 6'h04,
      ST_PWM = 6'h08,
      ST_READY = 6'h10,
      ST_DONE = 6'h20
   } ccc_state_t;

endpackage

// ### rtl/ccc_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module ccc_sync #(
   parameter int W = 1
) (
   input wire logic clk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable.
   input wire logic [W-1:0] d, // Asynchronous levels.
   output logic [W-1:0] q // Synchronised levels.
);
   logic [W-1:0] meta_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         q <= '0;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### rtl/ccc_top.sv
// Charge cycle controller: parameters, mode select and charge sequencing.
`timescale 1ns/1ps
`include "ccc_defines.svh"
module ccc_top
   import ccc_pkg::*;
#(
   parameter int READY_HOLD_CYC = `CCC_READY_HOLD_CYC
) (
   input wire logic CLK_SYS, // 125 MHz system clock.
   input wire logic SRST, // Synchronous reset, active high.
   input wire logic CLK_EN, // Freezes all state while low.
   input wire ccc_sense_t SENSE, // Asynchronous analog levels.
   input wire logic WR_STB, // Host register write strobe.
   input wire logic [2:0] WR_IDX, // Host register index.
   input wire logic [7:0] WR_DATA, // Host register write data.
   output ccc_params_t PARAMS, // Parameters as held.
   output logic [12:0] FLOAT_MV, // Float voltage level in mV.
   output logic [2:0] CUR_CMD, // Commanded charge current code.
   output logic CUR_LIMITED, // Current held below its programmed code.
   output logic HIZ_EN, // High-impedance mode active.
   output logic PRECHG_EN, // Linear pre-charge source on.
   output logic PWM_EN, // PWM charger on.
   output logic [1:0] STAT, // Charge status code.
   output logic CYCLE_START // One-cycle pulse at a new charge cycle.
);

   // ---------------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------------
   ccc_sense_t sense;
   logic [9:0] sense_bits;

   // Every analog level passes two flip-flops before use.
   ccc_sync #(.W(10)) u_sync (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CLK_EN),
      .d(SENSE),
      .q(sense_bits)
   );
   assign sense = ccc_sense_t'(sense_bits);

   // ---------------------------------------------------------------------
   // Parameter registers
   // ---------------------------------------------------------------------
   ccc_params_t par_reg;
   logic por_prev_reg;
   logic por_rise;
   logic por_restore;
   logic wr_cfg1;
   logic wr_cur;
   logic rst_req;
   logic dis_set;

   // Supply reset edge and the host events that restart charging.
   assign por_rise = sense.vin_ok & ~por_prev_reg;
   assign por_restore = por_rise & sense.below_weak;
   assign wr_cfg1 = WR_STB & (WR_IDX == `CCC_IDX_CFG1);
   assign wr_cur = WR_STB & (WR_IDX == `CCC_IDX_CUR);
   assign rst_req = wr_cur & WR_DATA[`CCC_RST_BIT];
   assign dis_set = wr_cfg1 & WR_DATA[`CCC_DIS_BIT];

   // Tracks the synchronised supply reset level for edge detection.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         por_prev_reg <= 1'b0;
      end else if (CLK_EN) begin
         por_prev_reg <= sense.vin_ok;
      end
   end

   // Defaults on reset, reset bit or weak-battery supply reset; else writes.
   always_ff @(posedge CLK_SYS) begin
      if (SRST || (CLK_EN && (por_restore || rst_req))) begin
         par_reg.float_voltage_code <= `CCC_DEF_FLOAT;
         par_reg.charge_current_code <= `CCC_DEF_CHG;
         par_reg.termination_current_code <= `CCC_DEF_TERM;
         par_reg.weak_battery_threshold <= `CCC_DEF_WEAK;
         par_reg.termination_enable <= `CCC_DEF_TE;
         par_reg.charge_disable <= 1'b0;
         par_reg.high_impedance_select <= 1'b0;
      end else if (CLK_EN) begin
         if (wr_cfg1) begin
            par_reg.weak_battery_threshold <=
               WR_DATA[`CCC_WEAK_MSB:`CCC_WEAK_LSB];
            par_reg.termination_enable <= WR_DATA[`CCC_TE_BIT];
            par_reg.charge_disable <= WR_DATA[`CCC_DIS_BIT];
            par_reg.high_impedance_select <= WR_DATA[`CCC_HZ_BIT];
         end
         if (WR_STB && (WR_IDX == `CCC_IDX_FLOAT)) begin
            par_reg.float_voltage_code <=
               WR_DATA[`CCC_FLOAT_MSB:`CCC_FLOAT_LSB];
         end
         if (wr_cur) begin
            par_reg.charge_current_code <=
               WR_DATA[`CCC_CHG_MSB:`CCC_CHG_LSB];
            par_reg.termination_current_code <=
               WR_DATA[`CCC_TERM_MSB:`CCC_TERM_LSB];
         end
      end
   end

   // ---------------------------------------------------------------------
   // Float voltage level
   // ---------------------------------------------------------------------
   logic [5:0] float_eff;
   logic [12:0] float_mv_next;

   // Codes at and above the top code saturate at the maximum level.
   always_comb begin
      if (par_reg.float_voltage_code >= `CCC_FLOAT_MAX_CODE) begin
         float_eff = `CCC_FLOAT_MAX_CODE;
      end else begin
         float_eff = par_reg.float_voltage_code;
      end
      float_mv_next = 13'(`CCC_FLOAT_BASE_MV +
         `CCC_FLOAT_STEP_MV * {7'h00, float_eff});
   end

   // ---------------------------------------------------------------------
   // Charge current derating
   // ---------------------------------------------------------------------
   localparam int STEP_CYC = `CCC_DERATE_STEP_CYC;
   logic [10:0] step_cnt_reg;
   logic step_tick;
   logic [2:0] cur_reg;
   logic limit_req;

   // Heat or input sag both pull the commanded current down.
   assign limit_req = sense.tj_hot | sense.vin_below_hold;
   assign step_tick = (step_cnt_reg == 11'(STEP_CYC - 1));

   // Free-running interval that paces each derating step.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         step_cnt_reg <= 11'h000;
      end else if (CLK_EN) begin
         if (step_tick) begin
            step_cnt_reg <= 11'h000;
         end else begin
            step_cnt_reg <= step_cnt_reg + 11'h001;
         end
      end
   end

   // Steps down while limited, back up toward the programmed code otherwise.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         cur_reg <= `CCC_DEF_CHG;
      end else if (CLK_EN) begin
         if (cur_reg > par_reg.charge_current_code) begin
            cur_reg <= par_reg.charge_current_code;
         end else if (step_tick && limit_req && (cur_reg != 3'h0)) begin
            cur_reg <= cur_reg - 3'h1;
         end else if (step_tick && !limit_req &&
                      (cur_reg < par_reg.charge_current_code)) begin
            cur_reg <= cur_reg + 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Charge sequencer
   // ---------------------------------------------------------------------
   ccc_state_t state_reg;
   ccc_state_t state_next;
   logic [31:0] hold_cnt_reg;
   logic hold_done;
   logic cycle_start;

   // New-cycle events from the supply, the host and the recharge comparator.
   assign cycle_start = por_restore | dis_set | rst_req |
      ((state_reg == ST_DONE) & sense.below_rech);
   assign hold_done = (hold_cnt_reg == 32'(READY_HOLD_CYC - 1));

   // Next state; high impedance and supply loss take priority.
   always_comb begin
      state_next = state_reg;
      if (par_reg.high_impedance_select || !sense.vin_ok) begin
         state_next = ST_HIZ;
      end else if (cycle_start || par_reg.charge_disable) begin
         state_next = ST_IDLE;
      end else begin
         case (state_reg)
            ST_HIZ, ST_IDLE: begin
               state_next = sense.below_short ? ST_PRE : ST_PWM;
            end
            ST_PRE: begin
               if (!sense.below_short) begin
                  state_next = ST_PWM;
               end
            end
            ST_PWM: begin
               if (sense.below_short) begin
                  state_next = ST_PRE;
               end else if (par_reg.termination_enable &&
                            sense.at_float && sense.iout_below_term) begin
                  state_next = ST_READY;
               end
            end
            ST_READY: begin
               if (hold_done) begin
                  if (sense.batt_present && sense.src_present) begin
                     state_next = ST_DONE;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_DONE: begin
               state_next = ST_DONE;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state_reg <= ST_HIZ;
      end else if (CLK_EN) begin
         state_reg <= state_next;
      end
   end

   // Counts the READY hold after termination; cleared in every other state.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         hold_cnt_reg <= 32'h00000000;
      end else if (CLK_EN) begin
         if (state_reg == ST_READY && !hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
         end else begin
            hold_cnt_reg <= 32'h00000000;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------------
   // The mode, status and start outputs follow the next state so they stand with the state change.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         PARAMS <= '0;
         FLOAT_MV <= 13'h0000;
         CUR_CMD <= 3'h0;
         CUR_LIMITED <= 1'b0;
         HIZ_EN <= 1'b1;
         PRECHG_EN <= 1'b0;
         PWM_EN <= 1'b0;
         STAT <= `CCC_STAT_READY;
         CYCLE_START <= 1'b0;
      end else if (CLK_EN) begin
         PARAMS <= par_reg;
         FLOAT_MV <= float_mv_next;
         CUR_CMD <= cur_reg;
         CUR_LIMITED <= (cur_reg < par_reg.charge_current_code);
         HIZ_EN <= (state_next == ST_HIZ);
         PRECHG_EN <= (state_next == ST_PRE);
         PWM_EN <= (state_next == ST_PWM);
         CYCLE_START <= cycle_start & (state_next != ST_HIZ);
         if (state_next == ST_DONE) begin
            STAT <= `CCC_STAT_DONE;
         end else if (state_next == ST_PRE || state_next == ST_PWM) begin
            STAT <= `CCC_STAT_CHARGING;
         end else begin
            STAT <= `CCC_STAT_READY;
         end
      end
   end
endmodule

// ### dv/ccc_top_asserts.sv
// Concurrent checks on the charge cycle controller ports.
`timescale 1ns/1ps
`include "ccc_defines.svh"
module ccc_top_asserts
   import ccc_pkg::*;
#(
   parameter int READY_HOLD_CYC = `CCC_READY_HOLD_CYC
) (
   input wire logic CLK_SYS, // System clock.
   input wire logic SRST, // Synchronous reset.
   input wire logic CLK_EN, // Clock enable.
   input wire logic WR_STB, // Write strobe.
   input wire logic [2:0] WR_IDX, // Register index.
   input wire logic [7:0] WR_DATA, // Write data.
   input wire ccc_params_t PARAMS, // Held parameters.
   input wire logic [12:0] FLOAT_MV, // Float level in mV.
   input wire logic HIZ_EN, // High-impedance mode.
   input wire logic PRECHG_EN, // Pre-charge source on.
   input wire logic PWM_EN, // PWM charger on.
   input wire logic [1:0] STAT, // Status code.
   input wire logic CYCLE_START // New cycle pulse.
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   // ------------------------------------------------------------------
   // Mode and output relations
   // ------------------------------------------------------------------
   // All charging paths stay off while the block is in high impedance.
   hiz_all_off_a: assert property (
      HIZ_EN |-> !PRECHG_EN && !PWM_EN)
      else $error("charging active in high-impedance mode");
   one_source_a: assert property (!(PRECHG_EN && PWM_EN))
      else $error("pre-charge and PWM on together");
   float_map_a: assert property (
      FLOAT_MV != 13'h0000 |-> FLOAT_MV ==
      `CCC_FLOAT_BASE_MV + `CCC_FLOAT_STEP_MV *
      ((PARAMS.float_voltage_code > `CCC_FLOAT_MAX_CODE) ?
      `CCC_FLOAT_MAX_CODE : PARAMS.float_voltage_code))
      else $error("float level does not follow its code");
   // Written fields appear two enabled edges after the write edge.
   float_write_a: assert property (
      CLK_EN && WR_STB && WR_IDX == 3'h2
      ##1 CLK_EN ##1 CLK_EN |->
      PARAMS.float_voltage_code == $past(WR_DATA[7:2], 2))
      else $error("float code write not applied");
   cur_write_a: assert property (
      CLK_EN && WR_STB && WR_IDX == 3'h4
      && !WR_DATA[7] ##1 CLK_EN ##1 CLK_EN |->
      {PARAMS.charge_current_code, PARAMS.termination_current_code} ==
      {$past(WR_DATA[6:4], 2), $past(WR_DATA[2:0], 2)})
      else $error("current codes write not applied");
   start_pulse_a: assert property (
      CYCLE_START && CLK_EN |->
      !HIZ_EN ##1 !CYCLE_START)
      else $error("cycle start pulse malformed");
   start_cmd_a: assert property (
      CLK_EN && WR_STB && !HIZ_EN &&
      ((WR_IDX == 3'h1 && WR_DATA[2] && !WR_DATA[1] &&
      !PARAMS.charge_disable) || (WR_IDX == 3'h4 && WR_DATA[7]))
      |-> ##[1:4] CYCLE_START)
      else $error("host command did not start a cycle");
   dis_idle_a: assert property (PARAMS.charge_disable &&
      $past(PARAMS.charge_disable) |->
      STAT == `CCC_STAT_READY && !PWM_EN && !PRECHG_EN)
      else $error("charging while disabled");
   hiz_sel_a: assert property (PARAMS.high_impedance_select &&
      $past(PARAMS.high_impedance_select) |-> HIZ_EN)
      else $error("high-impedance select ignored");

   // Main scenarios reached.
   cover property (STAT == `CCC_STAT_DONE);
   cover property (PRECHG_EN ##[1:300] PWM_EN);
   cover property (CYCLE_START);
endmodule

bind ccc_top ccc_top_asserts #(.READY_HOLD_CYC(READY_HOLD_CYC)) u_asserts (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .CLK_EN(CLK_EN), .WR_STB(WR_STB),
   .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .PARAMS(PARAMS),
   .FLOAT_MV(FLOAT_MV), .HIZ_EN(HIZ_EN), .PRECHG_EN(PRECHG_EN),
   .PWM_EN(PWM_EN), .STAT(STAT), .CYCLE_START(CYCLE_START));

// ### dv/ccc_host_model.sv
// Host model that programs the controller through its write port.
`timescale 1ns/1ps
module ccc_host_model (
   input wire logic clk, // System clock.
   output logic wr_stb, // Write strobe.
   output logic [2:0] wr_idx, // Register index.
   output logic [7:0] wr_data // Write data.
);
   // Idle values at time zero.
   initial begin
      wr_stb = 1'b0;
      wr_idx = 3'h0;
      wr_data = 8'h00;
   end

   // One write held over exactly one rising edge; then the strobe drops and index and data are inverted.
   task automatic write(input logic [2:0] idx, input logic [7:0] data);
      @(negedge clk);
      wr_stb = 1'b1;
      wr_idx = idx;
      wr_data = data;
      @(negedge clk);
      wr_stb = 1'b0;
      wr_idx = ~idx;
      wr_data = ~data;
   endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the charge cycle controller.
`timescale 1ns/1ps
module tb_top;
   import ccc_pkg::*;
   localparam int HOLD = 20;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic wr_stb, cur_limited, hiz_en, prechg_en, pwm_en, cycle_start;
   logic [2:0] wr_idx, cur_cmd, prev;
   logic [7:0] wr_data, d, c1;
   logic [12:0] float_mv;
   logic [1:0] stat;
   ccc_sense_t sense = '0;
   ccc_params_t params;
   int failures = 0, total_checks = 0, cyc = 0, starts = 0, k = 0;
   int m_float = 2;
   int codes[8] = '{0, 1, 35, 46, 47, 48, 63, 0};

   // Clock at 125 MHz.
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   ccc_top #(.READY_HOLD_CYC(HOLD)) DUT (.CLK_SYS(clk_sys), .SRST(srst),
      .CLK_EN(clk_en), .SENSE(sense), .WR_STB(wr_stb), .WR_IDX(wr_idx),
      .WR_DATA(wr_data), .PARAMS(params), .FLOAT_MV(float_mv),
      .CUR_CMD(cur_cmd), .CUR_LIMITED(cur_limited), .HIZ_EN(hiz_en),
      .PRECHG_EN(prechg_en), .PWM_EN(pwm_en), .STAT(stat),
      .CYCLE_START(cycle_start));
   ccc_host_model HOST (.clk(clk_sys), .wr_stb(wr_stb), .wr_idx(wr_idx),
      .wr_data(wr_data));

   // Counts start pulses and cuts a hang short.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cycle_start === 1'b1) begin
         starts <= starts + 1;
      end
      if (cyc == 60000) begin
         failures = failures + 1;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Compares one value.
   task automatic chk(input string what, input logic [16:0] exp,
      input logic [16:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Compares the mode outputs as {hiz, pre-charge, pwm, status}.
   task automatic chk_state(input logic [4:0] exp);
      chk("mode", exp, {hiz_en, prechg_en, pwm_en, stat});
   endtask

   // Compares float code and level against the bench model.
   task automatic chk_float();
      chk("float code", m_float, params.float_voltage_code);
      chk("float mv", 3500 + 20 * (m_float > 47 ? 47 : m_float), float_mv);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'h54B7));
      step(12);
      srst = 1'b0;
      step(3);
      chk_float();
      chk_state(5'b10000);
      // Float codes across both ends of the table and past its top.
      for (int i = 0; i < 8; i++) begin
         m_float = (i == 7) ? $urandom_range(63) : codes[i];
         HOST.write(3'h2, 8'((m_float << 2) | ($urandom & 3)));
         step(2);
         chk_float();
      end
      d = 8'($urandom) & 8'h7F;
      c1 = 8'($urandom) & 8'h38;
      HOST.write(3'h4, d);
      HOST.write(3'h1, c1);
      step(2);
      chk("charge code", d[6:4], params.charge_current_code);
      chk("term code", d[2:0], params.termination_current_code);
      chk("weak", c1[5:4], params.weak_battery_threshold);
      chk("term enable", c1[3], params.termination_enable);
      // Unmapped index and a write with the clock enable low are ignored.
      HOST.write(3'h3, 8'hFF);
      clk_en = 1'b0;
      HOST.write(3'h2, 8'h10);
      clk_en = 1'b1;
      HOST.write(3'h1, 8'h00);
      step(2);
      chk_float();
      // Supply valid with a weak cell restores defaults and starts charging.
      sense.vin_ok = 1'b1;
      sense.batt_present = 1'b1;
      sense.src_present = 1'b1;
      sense.below_weak = 1'b1;
      sense.below_short = 1'b1;
      k = starts;
      step(5);
      m_float = 2;
      chk_float();
      chk("charge default", 0, params.charge_current_code);
      chk("starts", k + 1, starts);
      chk_state(5'b01001);
      sense.below_weak = 1'b0;
      sense.below_short = 1'b0;
      step(4);
      chk_state(5'b00101);
      // Termination off keeps PWM charging at the float level.
      sense.at_float = 1'b1;
      sense.iout_below_term = 1'b1;
      step(30);
      chk_state(5'b00101);
      HOST.write(3'h1, 8'h08);
      step(3);
      chk_state(5'b00000);
      step(HOLD + 2);
      chk_state(5'b00010);
      // Recharge threshold starts a new cycle.
      k = starts;
      sense.below_rech = 1'b1;
      sense.at_float = 1'b0;
      sense.iout_below_term = 1'b0;
      step(5);
      sense.below_rech = 1'b0;
      chk("starts", k + 1, starts);
      chk_state(5'b00101);
      // Charge disable, then the reset bit combined with a field write.
      k = starts;
      HOST.write(3'h1, 8'h0C);
      step(3);
      chk("starts", k + 1, starts);
      chk_state(5'b00000);
      HOST.write(3'h1, 8'h08);
      step(4);
      chk_state(5'b00101);
      k = starts;
      HOST.write(3'h4, 8'hF5);
      step(3);
      chk("starts", k + 1, starts);
      chk("charge default", 0, params.charge_current_code);
      chk_float();
      // High-impedance select and release.
      HOST.write(3'h1, 8'h02);
      step(4);
      chk_state(5'b10000);
      HOST.write(3'h1, 8'h00);
      step(4);
      chk_state(5'b00101);
      // A cell that sags under the short level falls back to pre-charge.
      sense.below_short = 1'b1;
      step(4);
      chk_state(5'b01001);
      sense.below_short = 1'b0;
      step(4);
      chk_state(5'b00101);
      // Current ramps up, derates on heat and on input sag, then recovers.
      HOST.write(3'h4, 8'h70);
      step(9000);
      chk("cur cmd", 7, cur_cmd);
      chk("limited", 0, cur_limited);
      sense.tj_hot = 1'b1;
      step(1300);
      chk("heat derate", 1, cur_cmd < 3'h7 && cur_cmd > 3'h4);
      chk("limited", 1, cur_limited);
      sense.tj_hot = 1'b0;
      sense.vin_below_hold = 1'b1;
      prev = cur_cmd;
      step(1300);
      chk("sag derate", 1,
         cur_cmd < prev && cur_cmd + 3'h2 >= prev);
      sense.vin_below_hold = 1'b0;
      step(9000);
      chk("cur cmd", 7, cur_cmd);
      tally_and_finish();
   end
endmodule
